// ### vsp_pkg.sv
// constants, register map and carrier types for the velocity scaled coil pwm
// assumes a single 200 MHz clock and an axi4-lite register port
// What this block does
// - coil a duty follows table sine, coil b duty follows table cosine
// - with scaling on, scale grows linearly with absolute ramp velocity
// - start amplitude comes from current_configuration bits 31:16
// - pwm_full_scale_velocity holds velocity where scale becomes full
// - current_configuration bit 8 switches velocity scaling on
// - at zero velocity scale equals (start amplitude + 1) / 2^17
// - scale rises linearly and saturates at 0.5 at full-scale velocity
// - duty stays between 0.5 minus scale and 0.5 plus scale
// - with hold scaling on, standstill uses the hold scale value
// - format 1000/1001, pwm on, switch velocity zero selects driver pwm mode
// - driver_pin_a carries phase a, driver_pin_b carries phase b
// - driver pwm mode drives multipurpose output two low
// - driver pwm mode samples driver error into three status bits
// - driver pwm mode holds driver_pin_c high for phase b mode
// - only the four driver-facing pins are driven in driver mode
// - pwm off restores serial pins and drives multipurpose output two high
// - in driver pwm mode a microstep offset shifts the table index
// - period register gives clock cycles per pwm period
// - pwm enable replaces step and direction outputs with pwm phases
package vsp_pkg;
  // ----------------------------------------
  // register indices, byte address = 4 * index
  // ----------------------------------------
  localparam logic [7:0] IDX_GENERAL = 8'h00;
  localparam logic [7:0] IDX_CURRENT = 8'h05;
  localparam logic [7:0] IDX_FULL_VEL = 8'h17;
  localparam logic [7:0] IDX_SWITCH_VEL = 8'h1d;
  localparam logic [7:0] IDX_PERIOD = 8'h1f;
  localparam logic [7:0] IDX_DRV_CTRL = 8'h20;
  localparam logic [7:0] IDX_HOLD = 8'h21;
  localparam logic [7:0] IDX_STATUS = 8'h22;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int PWM_EN_BIT = 21;
  localparam int SCALE_EN_BIT = 8;
  localparam int AMP_LSB = 16;
  localparam int FMT_LSB = 0;
  localparam int OFS_LSB = 8;
  localparam int HOLD_EN_BIT = 16;
  localparam int MODE_BIT = 8;
  localparam logic [3:0] FMT_DRV_A = 4'h8;
  localparam logic [3:0] FMT_DRV_B = 4'h9;
  // ----------------------------------------
  // reset values and scale constants
  // ----------------------------------------
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam logic [16:0] SCALE_HALF = 17'h1_0000; // 0.5 in 2^-17 units
  localparam int SCALE_FRAC = 17;
  localparam logic [4:0] DIV_TOP = 5'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic sclk;
    logic csn;
    logic mosi;
  } vsp_serial_s;
  typedef struct packed {
    logic pin_a;
    logic pin_b;
    logic pin_c;
    logic mp_two;
  } vsp_drv_s;
endpackage

// ### vsp_core.sv
// velocity scaled two-phase pwm generator with driver pin rerouting
// assumes table values and velocity arrive on aclk; driver error is async
`timescale 1ns/10ps
module vsp_core #(
  parameter int MS_W = 10,
  parameter int LUT_W = 9
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [MS_W-1:0] microstep_index,
  output logic [MS_W-1:0] table_index,
  input wire logic signed [LUT_W-1:0] table_sine,
  input wire logic signed [LUT_W-1:0] table_cosine,
  input wire logic signed [31:0] actual_velocity,
  input wire logic standstill,
  input wire logic step_in,
  input wire logic dir_in,
  input wire vsp_pkg::vsp_serial_s serial_in,
  input wire logic driver_error_in,
  output logic coil_a_out,
  output logic coil_b_out,
  output vsp_pkg::vsp_drv_s driver_out
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [31:0] general_configuration;
  logic [31:0] current_configuration;
  logic [31:0] pwm_full_scale_velocity;
  logic [31:0] mode_switch_velocity;
  logic [31:0] pwm_period_cycles;
  logic [31:0] driver_control;
  logic [31:0] hold_scale;
  logic [2:0] error_bits;
  logic [31:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic have_aw;
  logic have_w;

  wire pwm_out_en = general_configuration[vsp_pkg::PWM_EN_BIT];
  wire scale_en = current_configuration[vsp_pkg::SCALE_EN_BIT];
  wire [15:0] start_amplitude = current_configuration[vsp_pkg::AMP_LSB +: 16];
  wire [3:0] out_format = driver_control[vsp_pkg::FMT_LSB +: 4];
  wire [7:0] ms_offset = driver_control[vsp_pkg::OFS_LSB +: 8];
  wire hold_en = hold_scale[vsp_pkg::HOLD_EN_BIT];
  // driver pwm mode needs all three settings at once
  wire drv_mode = pwm_out_en && mode_switch_velocity == 32'h0000_0000 &&
    (out_format == vsp_pkg::FMT_DRV_A || out_format == vsp_pkg::FMT_DRV_B);

  // ----------------------------------------
  // axi4-lite write path
  // ----------------------------------------
  wire [7:0] w_idx = aw_addr[9:2];
  wire w_hit = aw_addr[31:10] == 22'h0 && aw_addr[1:0] == 2'h0;
  wire do_write = have_aw && have_w && !s_axi_bvalid;
  wire w_gen = w_hit && w_idx == vsp_pkg::IDX_GENERAL;
  wire w_cur = w_hit && w_idx == vsp_pkg::IDX_CURRENT;
  wire w_fvel = w_hit && w_idx == vsp_pkg::IDX_FULL_VEL;
  wire w_svel = w_hit && w_idx == vsp_pkg::IDX_SWITCH_VEL;
  wire w_per = w_hit && w_idx == vsp_pkg::IDX_PERIOD;
  wire w_drv = w_hit && w_idx == vsp_pkg::IDX_DRV_CTRL;
  wire w_hold = w_hit && w_idx == vsp_pkg::IDX_HOLD;
  wire w_any = w_gen || w_cur || w_fvel || w_svel || w_per || w_drv || w_hold;

  // byte-lane merge of the write data into an old register value
  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] dat, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = dat[8*b +: 8];
      end
    end
    return res;
  endfunction

  // address and data may arrive in either order; each is held until the response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      have_aw <= 1'b0;
      have_w <= 1'b0;
      aw_addr <= vsp_pkg::REG_RESET;
      w_data <= vsp_pkg::REG_RESET;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= vsp_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        have_aw <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        have_w <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= w_any ? vsp_pkg::RESP_OKAY : vsp_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        have_aw <= 1'b0;
        have_w <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // register stores; period and velocities steer the generator
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      general_configuration <= vsp_pkg::REG_RESET;
      current_configuration <= vsp_pkg::REG_RESET;
      pwm_full_scale_velocity <= vsp_pkg::REG_RESET;
      mode_switch_velocity <= vsp_pkg::REG_RESET;
      pwm_period_cycles <= vsp_pkg::REG_RESET;
      driver_control <= vsp_pkg::REG_RESET;
      hold_scale <= vsp_pkg::REG_RESET;
    end else if (do_write) begin
      if (w_gen) general_configuration <= merge(general_configuration, w_data, w_strb);
      if (w_cur) current_configuration <= merge(current_configuration, w_data, w_strb);
      if (w_fvel) pwm_full_scale_velocity <= merge(pwm_full_scale_velocity, w_data, w_strb);
      if (w_svel) mode_switch_velocity <= merge(mode_switch_velocity, w_data, w_strb);
      if (w_per) pwm_period_cycles <= merge(pwm_period_cycles, w_data, w_strb);
      if (w_drv) driver_control <= merge(driver_control, w_data, w_strb);
      if (w_hold) hold_scale <= merge(hold_scale, w_data, w_strb);
    end
  end

  // ----------------------------------------
  // axi4-lite read path
  // ----------------------------------------
  wire [7:0] r_idx = s_axi_araddr[9:2];
  wire r_hit = s_axi_araddr[31:10] == 22'h0 && s_axi_araddr[1:0] == 2'h0;
  wire [31:0] status_word = {23'h0, drv_mode, 5'h0, error_bits};
  logic [31:0] r_val;
  logic r_ok;
  always_comb begin
    r_val = 32'h0000_0000;
    r_ok = r_hit;
    if (!r_hit) r_ok = 1'b0;
    else if (r_idx == vsp_pkg::IDX_GENERAL) r_val = general_configuration;
    else if (r_idx == vsp_pkg::IDX_CURRENT) r_val = current_configuration;
    else if (r_idx == vsp_pkg::IDX_FULL_VEL) r_val = pwm_full_scale_velocity;
    else if (r_idx == vsp_pkg::IDX_SWITCH_VEL) r_val = mode_switch_velocity;
    else if (r_idx == vsp_pkg::IDX_PERIOD) r_val = pwm_period_cycles;
    else if (r_idx == vsp_pkg::IDX_DRV_CTRL) r_val = driver_control;
    else if (r_idx == vsp_pkg::IDX_HOLD) r_val = hold_scale;
    else if (r_idx == vsp_pkg::IDX_STATUS) r_val = status_word;
    else r_ok = 1'b0;
  end

  // one read in flight; data is captured at the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= vsp_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= r_val;
      s_axi_rresp <= r_ok ? vsp_pkg::RESP_OKAY : vsp_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------
  // velocity scale, serial long division
  // ----------------------------------------
  // divider trades 17 cycles of latency for no wide divider; scale lags velocity
  wire [31:0] abs_vel = actual_velocity[31] ? 32'(-actual_velocity) : actual_velocity;
  wire [31:0] clip_vel = abs_vel >= pwm_full_scale_velocity ? pwm_full_scale_velocity : abs_vel;
  wire [16:0] base_scale = 17'(start_amplitude) + 17'h1;
  wire [16:0] scale_span = vsp_pkg::SCALE_HALF - base_scale;
  logic [48:0] div_rem;
  logic [31:0] div_den;
  logic [16:0] div_q;
  logic [16:0] div_base;
  logic [4:0] div_i;
  logic div_busy;
  logic [16:0] lin_scale;
  wire [48:0] div_sub = 49'(div_den) << div_i;
  wire div_fit = div_rem >= div_sub;
  wire [16:0] next_q = div_q | (div_fit ? 17'(17'h1 << div_i) : 17'h0);

  // q = span * |v| / vmax, so scale runs linearly from base to one half
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_busy <= 1'b0;
      div_rem <= 49'h0;
      div_den <= 32'h0000_0000;
      div_q <= 17'h0;
      div_base <= 17'h0;
      div_i <= 5'h0;
      lin_scale <= vsp_pkg::SCALE_HALF;
    end else if (!div_busy) begin
      div_busy <= 1'b1;
      div_rem <= 49'(scale_span) * 49'(clip_vel);
      div_den <= pwm_full_scale_velocity;
      div_base <= base_scale;
      div_q <= 17'h0;
      div_i <= vsp_pkg::DIV_TOP;
    end else begin
      if (div_fit) div_rem <= div_rem - div_sub;
      div_q <= next_q;
      div_i <= div_i - 5'h1;
      if (div_i == 5'h0) begin
        div_busy <= 1'b0;
        // zero full-scale velocity means already at full scale
        lin_scale <= div_den == 32'h0 ? vsp_pkg::SCALE_HALF : div_base + next_q;
      end
    end
  end

  // hold scale wins at standstill, scaling off gives the full swing
  wire [16:0] hold_val = 17'(hold_scale[15:0]) + 17'h1;
  wire [16:0] eff_scale = (hold_en && standstill) ? hold_val :
    scale_en ? lin_scale : vsp_pkg::SCALE_HALF;

  // ----------------------------------------
  // pwm period counter and duty compare
  // ----------------------------------------
  // high = period/2 + round(period * scale * s / 2^(17+LUT_W-1))
  function automatic logic [31:0] high_time(input logic [31:0] per,
      input logic [16:0] scl, input logic signed [LUT_W-1:0] s);
    logic signed [63:0] prod;
    logic signed [63:0] half;
    logic signed [63:0] sum;
    prod = $signed({1'b0, scl}) * 64'(s) * $signed({1'b0, per});
    prod = (prod + (64'sd1 <<< (vsp_pkg::SCALE_FRAC + LUT_W - 2))) >>>
      (vsp_pkg::SCALE_FRAC + LUT_W - 1);
    half = $signed({32'h0, per}) >>> 1;
    sum = half + prod;
    if (sum < 64'sd0) sum = 64'sd0;
    if (sum > $signed({32'h0, per})) sum = $signed({32'h0, per});
    return sum[31:0];
  endfunction

  logic [31:0] pwm_cnt;
  logic [31:0] high_a;
  logic [31:0] high_b;
  logic phase_a;
  logic phase_b;
  wire per_end = pwm_cnt + 32'h1 >= pwm_period_cycles;
  wire [31:0] next_cnt = per_end ? 32'h0 : pwm_cnt + 32'h1;

  // duty latched once per period so a pulse is never cut mid-way
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwm_cnt <= 32'h0;
      high_a <= 32'h0;
      high_b <= 32'h0;
      phase_a <= 1'b0;
      phase_b <= 1'b0;
    end else begin
      pwm_cnt <= next_cnt;
      if (per_end) begin
        high_a <= high_time(pwm_period_cycles, eff_scale, table_sine);
        high_b <= high_time(pwm_period_cycles, eff_scale, table_cosine);
      end
      phase_a <= next_cnt < high_a;
      phase_b <= next_cnt < high_b;
    end
  end

  // ----------------------------------------
  // driver error synchroniser
  // ----------------------------------------
  logic [2:0] err_sync;
  logic err_level;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_sync <= 3'h0;
      err_level <= 1'b0;
      error_bits <= 3'h0;
    end else begin
      err_sync <= {err_sync[1:0], driver_error_in};
      if (err_sync[2] == err_sync[1]) err_level <= err_sync[2];
      // one error line serves all three bridge and temperature bits
      if (drv_mode) error_bits <= {3{err_level}};
    end
  end

  // ----------------------------------------
  // output pins
  // ----------------------------------------
  // offset only while the driver runs on voltage pwm
  wire [MS_W-1:0] ofs_index = microstep_index + (drv_mode ? MS_W'(ms_offset) : MS_W'(0));
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      table_index <= '0;
      coil_a_out <= 1'b0;
      coil_b_out <= 1'b0;
      driver_out <= '0;
    end else begin
      table_index <= ofs_index;
      coil_a_out <= pwm_out_en ? phase_a : step_in;
      coil_b_out <= pwm_out_en ? phase_b : dir_in;
      if (drv_mode) begin
        // four pins only; the rest of the driver is strapped on board
        driver_out.pin_a <= phase_a;
        driver_out.pin_b <= phase_b;
        driver_out.pin_c <= 1'b1;
        driver_out.mp_two <= 1'b0;
      end else begin
        // serial interface returns and mp two selects serial mode
        driver_out.pin_a <= serial_in.sclk;
        driver_out.pin_b <= serial_in.csn;
        driver_out.pin_c <= serial_in.mosi;
        driver_out.mp_two <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  mode_pins_a: assert property (@(posedge aclk) disable iff (!aresetn)
    drv_mode |=> !driver_out.mp_two && driver_out.pin_c)
    else $error("driver mode pins wrong");
  serial_back_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !pwm_out_en |=> driver_out.mp_two && driver_out.pin_b == $past(serial_in.csn))
    else $error("serial pins not restored");
  phase_route_a: assert property (@(posedge aclk) disable iff (!aresetn)
    drv_mode |=> driver_out.pin_a == $past(phase_a) && driver_out.pin_b == $past(phase_b))
    else $error("phase not routed to driver");
  coil_route_a: assert property (@(posedge aclk) disable iff (!aresetn)
    pwm_out_en |=> coil_a_out == $past(phase_a) && coil_b_out == $past(phase_b))
    else $error("coil outputs not pwm");
  step_pass_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !pwm_out_en |=> coil_a_out == $past(step_in) && coil_b_out == $past(dir_in))
    else $error("step dir not forwarded");
  scale_bound_a: assert property (@(posedge aclk) disable iff (!aresetn)
    eff_scale <= vsp_pkg::SCALE_HALF)
    else $error("scale above one half");
  zero_vel_a: assert property (@(posedge aclk) disable iff (!aresetn)
    div_busy && div_i == 5'h0 && div_rem == 49'h0 && div_den != 32'h0 && div_q == 17'h0
    |=> lin_scale == $past(div_base))
    else $error("zero velocity scale wrong");
  high_bound_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(per_end) |-> ##1 high_a <= pwm_period_cycles || $changed(pwm_period_cycles))
    else $error("high time exceeds period");
  err_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
    drv_mode && $stable(drv_mode) |=> error_bits == {3{$past(err_level)}})
    else $error("error bits not following");
  wr_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write |=> s_axi_bvalid)
    else $error("write response missing");
endmodule

// ### vsp_drv_model.sv
// behavioural model of the voltage-mode stepper driver on the far side
// assumes the driver pins arrive as the design's packed struct on aclk
`timescale 1ns/10ps
module vsp_drv_model (
  input wire logic aclk,
  input wire vsp_pkg::vsp_drv_s drv,
  input wire logic fault_cmd,
  output logic err_line
);
  // --------------------------------
  // released data-out line
  // --------------------------------
  logic last_err = 1'b0;
  wire err_sel = !drv.mp_two && drv.pin_c;
  // a released line shows the inverse of its last flag, so a stale level never reads as valid
  always @(posedge aclk) begin
    if (err_sel) last_err <= fault_cmd;
  end
  // --------------------------------
  // error report
  // --------------------------------
  // flags only show with serial mode deselected and phase b mode high
  assign err_line = err_sel ? fault_cmd : ~last_err;
endmodule

// ### velocity_scaled_coil_pwm_tb.sv
// self-checking bench for vsp_core with the driver model on its far side
// assumes axi4-lite answers come within the bench's bounded waits
`timescale 1ns/10ps
module velocity_scaled_coil_pwm_tb;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, stand, step, dir, fault, err, ca, cb;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [9:0] ms_idx, tbl_idx;
  logic signed [8:0] sine, cosine;
  logic signed [31:0] vel;
  vsp_pkg::vsp_serial_s ser;
  vsp_pkg::vsp_drv_s drv;
  int errors = 0;
  int n_compared = 0;
  vsp_core DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .microstep_index(ms_idx), .table_index(tbl_idx),
    .table_sine(sine), .table_cosine(cosine), .actual_velocity(vel),
    .standstill(stand), .step_in(step), .dir_in(dir), .serial_in(ser),
    .driver_error_in(err), .coil_a_out(ca), .coil_b_out(cb), .driver_out(drv));
  vsp_drv_model MDL (.aclk(aclk), .drv(drv), .fault_cmd(fault), .err_line(err));
  // --------------------------------
  // helpers
  // --------------------------------
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= {22'h0, idx, 2'h0};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 200);
    bready <= 1'b0;
    chk({bvalid, bresp}, {1'b1, er});
  endtask
  task automatic rd(input logic [7:0] idx, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= {22'h0, idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 200);
    rready <= 1'b0;
    chk({rvalid, rresp, rdata}, {1'b1, er, ed});
  endtask
  // reference scale in 2^-17 units; long counts use longint to avoid overflow
  function automatic longint scale(int en, int amp, int vmax, int v, int hold, int hv);
    longint a;
    if (hold != 0) return hv + 1;
    if (en == 0 || vmax == 0) return 65536;
    a = (v < 0) ? -v : v;
    if (a > vmax) a = vmax;
    return (amp + 1) + (longint'(65535 - amp) * a) / vmax;
  endfunction
  function automatic int high(int p, longint sc, int s);
    longint h;
    h = p / 2 + (p * sc * s + (1 << 24)) / (1 << 25);
    if (h > p) h = p;
    return int'(h);
  endfunction
  // count high cycles over whole periods, after the scale divider settles
  task automatic meas(input int p, input int hs, input int hc);
    int ha, hb;
    ha = 0;
    hb = 0;
    repeat (3 * p + 60) @(posedge aclk);
    repeat (4 * p) begin
      @(posedge aclk);
      ha += ca;
      hb += cb;
    end
    chk(40'(ha), 40'(4 * hs));
    chk(40'(hb), 40'(4 * hc));
  endtask
  task automatic end_of_test();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // --------------------------------
  // clock, watchdog, sequence
  // --------------------------------
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  initial begin
    #200000;
    errors++;
    end_of_test();
  end
  initial begin
    int c_en[5] = '{0, 1, 1, 1, 1};
    int c_v[5] = '{0, 0, -1500, 500, 0};
    int c_hd[5] = '{0, 0, 0, 0, 1};
    logic [7:0] idx_l[8] = '{8'h00, 8'h05, 8'h17, 8'h1d, 8'h1f, 8'h20, 8'h21, 8'h22};
    logic [3:0] fmt_l[3] = '{4'h8, 4'h9, 4'h3};
    logic [4:0] h[24];
    logic [7:0] ofs;
    int amp, hv, s, c;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, step, dir, stand, fault} = '0;
    {awaddr, wdata, araddr, ms_idx, sine, cosine, vel, ser} = '0;
    wstrb = 4'hf;
    void'($urandom(32'hc2cf));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (idx_l[i]) rd(idx_l[i], 32'h0, vsp_pkg::RESP_OKAY);
    rd(8'h40, 32'h0, vsp_pkg::RESP_SLVERR);
    wr(8'h40, 32'h1, vsp_pkg::RESP_SLVERR);
    s = $urandom;
    wr(vsp_pkg::IDX_SWITCH_VEL, s, vsp_pkg::RESP_OKAY);
    rd(vsp_pkg::IDX_SWITCH_VEL, s, vsp_pkg::RESP_OKAY);
    wr(vsp_pkg::IDX_SWITCH_VEL, 32'h0, vsp_pkg::RESP_OKAY);
    wr(vsp_pkg::IDX_PERIOD, 32'd20, vsp_pkg::RESP_OKAY);
    wr(vsp_pkg::IDX_GENERAL, 32'h0020_0000, vsp_pkg::RESP_OKAY);
    // scaled duty cases; scaling off in the first, on in the other four
    for (int k = 0; k < 5; k++) begin
      amp = ($urandom & 32'hfffe) | 1;
      hv = $urandom & 32'h7fff;
      s = $urandom_range(255);
      c = $urandom_range(255);
      wr(vsp_pkg::IDX_CURRENT, {amp[15:0], 7'h0, c_en[k] != 0, 8'h0}, 2'h0);
      wr(vsp_pkg::IDX_FULL_VEL, 32'd1000, vsp_pkg::RESP_OKAY);
      wr(vsp_pkg::IDX_HOLD, {15'h0, c_hd[k] != 0, hv[15:0]}, vsp_pkg::RESP_OKAY);
      vel <= c_v[k];
      stand <= (c_hd[k] != 0);
      sine <= 9'(s);
      cosine <= 9'(c);
      meas(20, high(20, scale(c_en[k], amp, 1000, c_v[k], c_hd[k], hv), s),
        high(20, scale(c_en[k], amp, 1000, c_v[k], c_hd[k], hv), c));
    end
    vel <= 0; // drive mode ignores velocity; pwm enable, format and the switch velocity register gate it
    foreach (fmt_l[i]) begin
      ofs = 8'($urandom);
      wr(vsp_pkg::IDX_DRV_CTRL, {16'h0, ofs, 4'h0, fmt_l[i]}, vsp_pkg::RESP_OKAY);
      ms_idx <= 10'($urandom);
      fault <= 1'b1;
      repeat (12) @(posedge aclk);
      if (i < 2) begin
        chk(40'(tbl_idx), 40'(10'(ms_idx + 10'(ofs))));
        repeat (30) @(posedge aclk) chk(40'(drv), 40'({ca, cb, 2'b10}));
        rd(vsp_pkg::IDX_STATUS, 32'h107, vsp_pkg::RESP_OKAY);
        fault <= 1'b0;
        repeat (12) @(posedge aclk);
        rd(vsp_pkg::IDX_STATUS, 32'h100, vsp_pkg::RESP_OKAY);
      end else begin
        chk(40'({tbl_idx, drv.mp_two}), 40'({ms_idx, 1'b1}));
      end
    end
    wr(vsp_pkg::IDX_DRV_CTRL, 32'h8, vsp_pkg::RESP_OKAY);
    wr(vsp_pkg::IDX_SWITCH_VEL, 32'd5, vsp_pkg::RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk(40'(drv.mp_two), 40'h1);
    wr(vsp_pkg::IDX_SWITCH_VEL, 32'h0, vsp_pkg::RESP_OKAY);
    wr(vsp_pkg::IDX_GENERAL, 32'h0, vsp_pkg::RESP_OKAY);
    for (int i = 0; i < 24; i++) begin
      @(posedge aclk);
      if (i >= 2) chk(40'({ca, cb, drv}), 40'({h[i-2], 1'b1}));
      h[i] = 5'($urandom);
      {step, dir, ser} <= h[i];
    end
    end_of_test();
  end
endmodule
